// >>> als_cmp.sv
// Threshold comparators shared by alarm and level steering
`timescale 1ns/1ns
`default_nettype none
module als_cmp #(
	parameter int NTHR = 3 // Number of thresholds
) (
	als_mon_if.cmp mon // Value and thresholds in, results out
);
	// ------------------------------------------------------------
	// One strict compare per threshold
	// ------------------------------------------------------------
	for (genvar i = 0; i < NTHR; i++) begin : g_thr
		// Equal counts as not crossed, keeping a hysteresis-free edge
		assign mon.above[i] = mon.sel_value > mon.thr[i];
	end

	// Low alarm looks only at the first threshold
	assign mon.below = mon.sel_value < mon.thr[0];
endmodule
`default_nettype wire

// >>> als_ext_model.sv
// Partner model: the sensor side that feeds the monitored sources
`timescale 1ns/1ns
`default_nettype none
module als_ext_model #(
	parameter int DW = 8 // Data path width
) (
	input  wire logic          clk_i,  // Block clock
	output logic      [DW-1:0] temp_o, // Temperature amplifier value
	output logic      [DW-1:0] amp_o,  // Input amplifier value
	output logic      [DW-1:0] gain_o, // Gain stage value
	output logic      [DW-1:0] volt_o, // Voltage-mode value
	output logic      [DW-1:0] norm_o  // Conditioned value outside alarm
);
	// Quiet sources at time zero
	initial begin
		{temp_o, amp_o, gain_o, volt_o} = '0;
		norm_o = 8'h5a;
	end

	// One source gets the test value, the rest a decoy so a wrong pick shows
	task automatic drive(input int s, input logic [DW-1:0] v, input logic [DW-1:0] rest);
		@(posedge clk_i);
		temp_o <= (s == 0) ? v : rest;
		amp_o  <= (s == 1) ? v : rest;
		gain_o <= (s == 2) ? v : rest;
		volt_o <= (s == 3) ? v : rest;
	endtask
endmodule
`default_nettype wire

// >>> als_mon_if.sv
// Interface: monitored value, thresholds and compare results between block parts
`timescale 1ns/1ns
`default_nettype none
interface als_mon_if;
	logic [2:0]      src;       // Selected source code
	logic [7:0]      sel_value; // Value under watch
	logic [2:0][7:0] thr;       // Thresholds, ascending
	logic [2:0]      above;     // Value above each threshold
	logic            below;     // Value below the first threshold

	modport sel (input src, output sel_value);
	modport cmp (input sel_value, input thr, output above, output below);
	modport ctl (output src, output thr, input sel_value, input above, input below);
endinterface
`default_nettype wire

// >>> als_pkg.sv
// Package: constants, field positions and types of the alarm and level-steering block
package als_pkg;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] ALS_OFS_CTRL     = 8'h00; // Mode and output-stage enables
	localparam logic [7:0] ALS_OFS_STAT     = 8'h01; // Live alarm and level state
	localparam logic [7:0] ALS_OFS_IRQ_ST   = 8'h02; // Sticky events, write one to clear
	localparam logic [7:0] ALS_OFS_IRQ_MASK = 8'h03; // Event enables
	localparam logic [7:0] ALS_OFS_DOUT     = 8'h04; // Digital output as driven
	localparam logic [7:0] ALS_OFS_SEL      = 8'h1e; // monitor_input_select
	localparam logic [7:0] ALS_OFS_LO_TRIG  = 8'h1f; // low_threshold_level_one
	localparam logic [7:0] ALS_OFS_LO_OUT   = 8'h20; // low_alarm_value_level_two
	localparam logic [7:0] ALS_OFS_HI_TRIG  = 8'h21; // high_threshold_level_three
	localparam logic [7:0] ALS_OFS_HI_OUT   = 8'h22; // high_alarm_output_value

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int ALS_CTRL_ALARM_EN = 0; // Alarm mode requested
	localparam int ALS_CTRL_LEVEL_EN = 1; // Level-steering mode requested
	localparam int ALS_CTRL_CMO_EN   = 2; // Current-mode output stage on
	localparam int ALS_CTRL_VMO_EN   = 3; // Voltage-mode output stage on
	localparam int ALS_SEL_ALARM_LSB = 5; // Alarm source in bits 7:5
	localparam int ALS_SEL_LEVEL_LSB = 5; // Level source in bits 6:5
	localparam int ALS_IRQ_LOW       = 0; // Entered low alarm
	localparam int ALS_IRQ_HIGH      = 1; // Entered high alarm
	localparam int ALS_IRQ_LEVEL     = 2; // Level code changed

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [7:0] ALS_RST_BYTE = 8'h00; // Every byte register
	localparam logic [3:0] ALS_RST_CTRL = 4'h0;  // No mode active
	localparam logic [2:0] ALS_RST_IRQ  = 3'h0;  // No events, all masked

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	// Monitored source codes
	typedef enum logic [2:0] {
		ALS_SRC_TEMP = 3'h0,
		ALS_SRC_AMP  = 3'h1,
		ALS_SRC_GAIN = 3'h2,
		ALS_SRC_VOLT = 3'h3,
		ALS_SRC_LVL0 = 3'h4,
		ALS_SRC_LVL1 = 3'h5
	} als_src_t;

	// Output mode, one-hot
	typedef enum logic [3:0] {
		ALS_ST_NORMAL = 4'h1,
		ALS_ST_LOW    = 4'h2,
		ALS_ST_HIGH   = 4'h4,
		ALS_ST_LEVEL  = 4'h8
	} als_state_t;

endpackage

// >>> als_sel.sv
// Monitored input multiplexer
`timescale 1ns/1ns
`default_nettype none
module als_sel (
	als_mon_if.sel          mon,    // Source code in, value out
	input  wire logic [7:0] temp_i, // temperature_amp_output
	input  wire logic [7:0] amp_i,  // input_amp_output
	input  wire logic [7:0] gain_i, // gain_stage_output
	input  wire logic [7:0] volt_i, // voltage_mode_output
	input  wire logic       lvl0_i, // level_code_bit_zero as driven
	input  wire logic       lvl1_i  // level_code_bit_one as driven
);
	// ------------------------------------------------------------
	// Source choice
	// ------------------------------------------------------------
	// A level bit is widened to a full byte so the same compares apply
	always_comb begin
		case (mon.src)
			als_pkg::ALS_SRC_TEMP: mon.sel_value = temp_i;
			als_pkg::ALS_SRC_AMP:  mon.sel_value = amp_i;
			als_pkg::ALS_SRC_GAIN: mon.sel_value = gain_i;
			als_pkg::ALS_SRC_VOLT: mon.sel_value = volt_i;
			als_pkg::ALS_SRC_LVL0: mon.sel_value = {8{lvl0_i}};
			als_pkg::ALS_SRC_LVL1: mon.sel_value = {8{lvl1_i}};
			// Unused codes fall back to the temperature path
			default:               mon.sel_value = temp_i;
		endcase
	end
endmodule
`default_nettype wire

// >>> als_top.sv
// Alarm and level-steering block: registers, mode control and output drive
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ns
`default_nettype none
module als_top #(
	parameter int DW = 8 // Data path width
) (
	input  wire logic          clk_i,         // 100 MHz clock
	input  wire logic          sys_rst_i,     // Synchronous reset, active high
	input  wire logic [7:0]    addr_i,        // Register address
	input  wire logic [7:0]    wdata_i,       // Write data
	input  wire logic          wr_i,          // Write strobe
	input  wire logic          rd_i,          // Read strobe
	output logic      [7:0]    rdata_o,       // Read data, cycle after strobe
	input  wire logic [DW-1:0] temp_i,        // temperature_amp_output
	input  wire logic [DW-1:0] amp_i,         // input_amp_output
	input  wire logic [DW-1:0] gain_i,        // gain_stage_output
	input  wire logic [DW-1:0] volt_i,        // voltage_mode_output
	input  wire logic [DW-1:0] normal_value_i, // Conditioned value outside alarm
	output logic      [DW-1:0] digital_output_value_o, // Digital output
	output logic               level_code_bit_zero_o,  // Level code, low bit
	output logic               level_code_bit_one_o,   // Level code, high bit
	output logic               alarm_low_o,   // Low alarm holding
	output logic               alarm_high_o,  // High alarm holding
	output logic               irq_o          // Unmasked event pending
);

	// ------------------------------------------------------------
	// State record
	// ------------------------------------------------------------
	// All flops of the block in one record
	typedef struct packed {
		logic [3:0]          ctrl;     // Mode and stage enables
		logic [7:0]          sel;      // monitor_input_select
		logic [7:0]          lo_trig;  // low_threshold_level_one
		logic [7:0]          lo_out;   // low_alarm_value_level_two
		logic [7:0]          hi_trig;  // high_threshold_level_three
		logic [7:0]          hi_out;   // high_alarm_output_value
		logic [2:0]          irq_st;   // Sticky events
		logic [2:0]          irq_mask; // Event enables
		als_pkg::als_state_t state;    // Output mode
		logic [DW-1:0]       dout;     // Driven digital output
		logic [1:0]          lvl;      // Driven level code
		logic                alm_lo;   // Low alarm flag
		logic                alm_hi;   // High alarm flag
		logic [7:0]          rdata;    // Read answer
		logic                irq;      // Interrupt line
	} als_regs_t;

	als_regs_t state_q; // Registered state
	als_regs_t state_d; // Next state

	// ------------------------------------------------------------
	// Monitor path
	// ------------------------------------------------------------
	als_mon_if mon (); // Link to selector and comparators

	logic level_mode; // Level steering in force
	logic digital_output_value_mode; // Both output stages on
	logic alarm_mode; // Alarm allowed to act

	// Mode decode from the control register
	always_comb begin
		// Level steering dominates; alarm also needs a non-digital output
		level_mode = state_q.ctrl[als_pkg::ALS_CTRL_LEVEL_EN];
		digital_output_value_mode = state_q.ctrl[als_pkg::ALS_CTRL_CMO_EN]
			& state_q.ctrl[als_pkg::ALS_CTRL_VMO_EN];
		alarm_mode = state_q.ctrl[als_pkg::ALS_CTRL_ALARM_EN]
			& ~level_mode & ~digital_output_value_mode;
	end

	// Source code depends on which mode reads the selector byte
	always_comb begin
		if (level_mode) begin
			// Two bits only, so just the four analog sources are reachable
			mon.src = {1'b0, state_q.sel[als_pkg::ALS_SEL_LEVEL_LSB +: 2]};
		end else begin
			mon.src = state_q.sel[als_pkg::ALS_SEL_ALARM_LSB +: 3];
		end
	end

	// Threshold bytes feed both modes with the same ascending order
	// One driver for the whole vector; index 0 is the lowest threshold
	assign mon.thr = {state_q.hi_trig, state_q.lo_out, state_q.lo_trig};

	// Narrow the monitored inputs to the byte-wide compare path
	als_sel u_sel (
		.mon    (mon.sel),
		.temp_i (temp_i[7:0]),
		.amp_i  (amp_i[7:0]),
		.gain_i (gain_i[7:0]),
		.volt_i (volt_i[7:0]),
		.lvl0_i (state_q.lvl[0]),
		.lvl1_i (state_q.lvl[1])
	);

	als_cmp #(
		.NTHR (3)
	) u_cmp (
		.mon (mon.cmp)
	);

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------
	logic                wr_sel;   // Write to selector byte
	logic [2:0]          clr_mask; // Bits being cleared by software
	logic [2:0]          events;   // Events of this cycle
	logic [1:0]          lvl_code; // Level code from compares
	als_pkg::als_state_t target;   // Mode wanted now

	always_comb begin
		state_d  = state_q;
		wr_sel   = 1'b0;
		clr_mask = 3'h0;
		events   = 3'h0;

		// Register writes
		if (wr_i) begin
			case (addr_i)
				als_pkg::ALS_OFS_CTRL:     state_d.ctrl     = wdata_i[3:0];
				als_pkg::ALS_OFS_IRQ_ST:   clr_mask         = wdata_i[2:0];
				als_pkg::ALS_OFS_IRQ_MASK: state_d.irq_mask = wdata_i[2:0];
				als_pkg::ALS_OFS_SEL: begin
					state_d.sel = wdata_i;
					wr_sel      = 1'b1;
				end
				als_pkg::ALS_OFS_LO_TRIG:  state_d.lo_trig  = wdata_i;
				als_pkg::ALS_OFS_LO_OUT:   state_d.lo_out   = wdata_i;
				als_pkg::ALS_OFS_HI_TRIG:  state_d.hi_trig  = wdata_i;
				als_pkg::ALS_OFS_HI_OUT:   state_d.hi_out   = wdata_i;
				// Writes elsewhere are dropped
				default: ;
			endcase
		end

		// Level code: each crossed threshold steps the code up by one
		if (mon.above[2]) begin
			lvl_code = 2'h3;
		end else if (mon.above[1]) begin
			lvl_code = 2'h2;
		end else if (mon.above[0]) begin
			lvl_code = 2'h1;
		end else begin
			lvl_code = 2'h0;
		end

		// Mode wanted from the compares; low is checked first in case
		// software set the triggers the wrong way round
		if (level_mode) begin
			target = als_pkg::ALS_ST_LEVEL;
		end else if (alarm_mode && mon.below) begin
			target = als_pkg::ALS_ST_LOW;
		end else if (alarm_mode && mon.above[2]) begin
			target = als_pkg::ALS_ST_HIGH;
		end else begin
			// In range again, or alarm disabled
			target = als_pkg::ALS_ST_NORMAL;
		end
		state_d.state = target;

		// Events on entry to each alarm and on every level step
		events[als_pkg::ALS_IRQ_LOW]  = (target == als_pkg::ALS_ST_LOW)
			&& (state_q.state != als_pkg::ALS_ST_LOW);
		events[als_pkg::ALS_IRQ_HIGH] = (target == als_pkg::ALS_ST_HIGH)
			&& (state_q.state != als_pkg::ALS_ST_HIGH);
		events[als_pkg::ALS_IRQ_LEVEL] = (target == als_pkg::ALS_ST_LEVEL)
			&& (lvl_code != state_q.lvl);

		// Output drive per mode
		case (target)
			als_pkg::ALS_ST_LOW: begin
				state_d.dout   = DW'(state_q.lo_out);
				state_d.lvl    = 2'h0;
				state_d.alm_lo = 1'b1;
				state_d.alm_hi = 1'b0;
			end
			als_pkg::ALS_ST_HIGH: begin
				state_d.dout   = DW'(state_q.hi_out);
				state_d.lvl    = 2'h0;
				state_d.alm_lo = 1'b0;
				state_d.alm_hi = 1'b1;
			end
			als_pkg::ALS_ST_LEVEL: begin
				// Output value is untouched; only the pins carry the code
				state_d.dout   = normal_value_i;
				state_d.lvl    = lvl_code;
				state_d.alm_lo = 1'b0;
				state_d.alm_hi = 1'b0;
			end
			als_pkg::ALS_ST_NORMAL: begin
				state_d.dout   = normal_value_i;
				state_d.lvl    = 2'h0;
				state_d.alm_lo = 1'b0;
				state_d.alm_hi = 1'b0;
			end
			// Unreachable codes go back to plain output
			default: begin
				state_d.dout   = normal_value_i;
				state_d.lvl    = 2'h0;
				state_d.alm_lo = 1'b0;
				state_d.alm_hi = 1'b0;
			end
		endcase

		// Sticky events: a new event beats a clear in the same cycle
		state_d.irq_st = (state_q.irq_st & ~clr_mask) | events;
		state_d.irq    = |(state_d.irq_st & state_d.irq_mask);

		// Read answer, held for the single cycle after the strobe
		state_d.rdata = 8'h00;
		if (rd_i) begin
			case (addr_i)
				als_pkg::ALS_OFS_CTRL:     state_d.rdata = {4'h0, state_q.ctrl};
				als_pkg::ALS_OFS_STAT:     state_d.rdata = {state_q.state,
					state_q.lvl, state_q.alm_hi, state_q.alm_lo};
				als_pkg::ALS_OFS_IRQ_ST:   state_d.rdata = {5'h00, state_q.irq_st};
				als_pkg::ALS_OFS_IRQ_MASK: state_d.rdata = {5'h00, state_q.irq_mask};
				als_pkg::ALS_OFS_DOUT:     state_d.rdata = state_q.dout[7:0];
				als_pkg::ALS_OFS_SEL:      state_d.rdata = state_q.sel;
				als_pkg::ALS_OFS_LO_TRIG:  state_d.rdata = state_q.lo_trig;
				als_pkg::ALS_OFS_LO_OUT:   state_d.rdata = state_q.lo_out;
				als_pkg::ALS_OFS_HI_TRIG:  state_d.rdata = state_q.hi_trig;
				als_pkg::ALS_OFS_HI_OUT:   state_d.rdata = state_q.hi_out;
				// Unmapped addresses read as zero
				default:                   state_d.rdata = 8'h00;
			endcase
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	// Synchronous reset to idle with every byte cleared
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			state_q.ctrl     <= als_pkg::ALS_RST_CTRL;
			state_q.sel      <= als_pkg::ALS_RST_BYTE;
			state_q.lo_trig  <= als_pkg::ALS_RST_BYTE;
			state_q.lo_out   <= als_pkg::ALS_RST_BYTE;
			state_q.hi_trig  <= als_pkg::ALS_RST_BYTE;
			state_q.hi_out   <= als_pkg::ALS_RST_BYTE;
			state_q.irq_st   <= als_pkg::ALS_RST_IRQ;
			state_q.irq_mask <= als_pkg::ALS_RST_IRQ;
			state_q.state    <= als_pkg::ALS_ST_NORMAL;
			state_q.dout     <= '0;
			state_q.lvl      <= 2'h0;
			state_q.alm_lo   <= 1'b0;
			state_q.alm_hi   <= 1'b0;
			state_q.rdata    <= 8'h00;
			state_q.irq      <= 1'b0;
		end else begin
			state_q <= state_d;
		end
	end

	// ------------------------------------------------------------
	// Outputs, each straight from a flop
	// ------------------------------------------------------------
	assign rdata_o                = state_q.rdata;
	assign digital_output_value_o = state_q.dout;
	assign level_code_bit_zero_o  = state_q.lvl[0];
	assign level_code_bit_one_o   = state_q.lvl[1];
	assign alarm_low_o            = state_q.alm_lo;
	assign alarm_high_o           = state_q.alm_hi;
	assign irq_o                  = state_q.irq;

endmodule
`default_nettype wire

// >>> als_top_sva.sv
// Checker: port-level properties of the alarm and level-steering block
`timescale 1ns/1ns
`default_nettype none
module als_top_sva #(
	parameter int DW = 8 // Data path width
) (
	input wire logic          clk_i,
	input wire logic          sys_rst_i,
	input wire logic [7:0]    addr_i,
	input wire logic [7:0]    wdata_i,
	input wire logic          wr_i,
	input wire logic          rd_i,
	input wire logic [7:0]    rdata_o,
	input wire logic [DW-1:0] temp_i,
	input wire logic [DW-1:0] amp_i,
	input wire logic [DW-1:0] gain_i,
	input wire logic [DW-1:0] volt_i,
	input wire logic [DW-1:0] normal_value_i,
	input wire logic [DW-1:0] digital_output_value_o,
	input wire logic          level_code_bit_zero_o,
	input wire logic          level_code_bit_one_o,
	input wire logic          alarm_low_o,
	input wire logic          alarm_high_o,
	input wire logic          irq_o
);
	// ------------------------------------------------------------
	// Shadow copies of the bytes, kept from bus writes
	// ------------------------------------------------------------
	logic [7:0]    ctl_q, sel_q, lo_q, lo_out_q, hi_q, hi_out_q; // Written values
	logic [DW-1:0] asrc;  // Value under alarm watch
	logic [DW-1:0] lsrc;  // Value under level watch
	logic [1:0]    code;  // Expected level code
	logic          alm;   // Alarm mode really in effect

	// Shadows follow writes on the edge the block takes them
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			{ctl_q, sel_q, lo_q, lo_out_q, hi_q, hi_out_q} <= '0;
		end else if (wr_i) begin
			case (addr_i)
				als_pkg::ALS_OFS_CTRL:    ctl_q    <= wdata_i;
				als_pkg::ALS_OFS_SEL:     sel_q    <= wdata_i;
				als_pkg::ALS_OFS_LO_TRIG: lo_q     <= wdata_i;
				als_pkg::ALS_OFS_LO_OUT:  lo_out_q <= wdata_i;
				als_pkg::ALS_OFS_HI_TRIG: hi_q     <= wdata_i;
				als_pkg::ALS_OFS_HI_OUT:  hi_out_q <= wdata_i;
				default: ;
			endcase
		end
	end

	// Source pick and level code, taken from the live pins
	always_comb begin
		case (sel_q[7:5])
			3'h1:    asrc = amp_i;
			3'h2:    asrc = gain_i;
			3'h3:    asrc = volt_i;
			3'h4:    asrc = {DW{level_code_bit_zero_o}};
			3'h5:    asrc = {DW{level_code_bit_one_o}};
			default: asrc = temp_i;
		endcase
		case (sel_q[6:5])
			2'h1:    lsrc = amp_i;
			2'h2:    lsrc = gain_i;
			2'h3:    lsrc = volt_i;
			default: lsrc = temp_i;
		endcase
		code = (lsrc > hi_q) ? 2'h3 : (lsrc > lo_out_q) ? 2'h2 : (lsrc > lo_q) ? 2'h1 : 2'h0;
		alm  = ctl_q[0] && !ctl_q[1] && !(ctl_q[2] && ctl_q[3]);
	end

	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	rdata_idle_a: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
		else $error("read data not zero outside read answer");
	alarm_excl_a: assert property (!(alarm_low_o && alarm_high_o))
		else $error("both alarms at once");
	low_enter_a: assert property (alm && asrc < lo_q |=> alarm_low_o)
		else $error("low alarm missed");
	high_enter_a: assert property (alm && asrc >= lo_q && asrc > hi_q |=> alarm_high_o)
		else $error("high alarm missed");
	low_value_a: assert property (alarm_low_o |-> digital_output_value_o == lo_out_q)
		else $error("low alarm output byte wrong");
	high_value_a: assert property (alarm_high_o |-> digital_output_value_o == hi_out_q)
		else $error("high alarm output byte wrong");
	normal_out_a: assert property (!alarm_low_o && !alarm_high_o && !$past(sys_rst_i)
		|-> digital_output_value_o == $past(normal_value_i))
		else $error("normal output value wrong");
	both_stage_a: assert property (ctl_q[2] && ctl_q[3] |=> !alarm_low_o && !alarm_high_o)
		else $error("alarm active with both output stages on");
	level_wins_a: assert property (ctl_q[1] |=> !alarm_low_o && !alarm_high_o)
		else $error("alarm active in level mode");
	level_code_a: assert property (ctl_q[1]
		|=> {level_code_bit_one_o, level_code_bit_zero_o} == $past(code))
		else $error("level code wrong");

	cover property (alarm_low_o);
	cover property (alarm_high_o);
	cover property (level_code_bit_one_o && level_code_bit_zero_o);
	cover property (irq_o);
endmodule
`default_nettype wire

// >>> tb_als_top.sv
// Testbench: register access, alarm, output-stage and level-steering tests
`timescale 1ns/1ns
`default_nettype none
module tb_als_top;
	logic       clk_i, sys_rst_i, wr_i, rd_i; // Clock, reset, strobes
	logic [7:0] addr_i, wdata_i, rdata_o;     // Register bus
	logic [7:0] temp, amp, gain, volt, norm, dout; // Data path
	logic       lvl0, lvl1, alo, ahi, irq;    // Flag outputs
	int         fails, cmp_count, i, s;       // Counters and loop indices
	logic [7:0] vals [6] = '{8'h40, 8'h41, 8'h80, 8'h81, 8'hc1, 8'h10}; // Level probes
	logic [1:0] codes [6] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h3, 2'h0};     // Codes expected

	als_ext_model #(.DW(8)) m (.clk_i(clk_i), .temp_o(temp), .amp_o(amp), .gain_o(gain),
		.volt_o(volt), .norm_o(norm));
	als_top #(.DW(8)) uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .temp_i(temp),
		.amp_i(amp), .gain_i(gain), .volt_i(volt), .normal_value_i(norm),
		.digital_output_value_o(dout), .level_code_bit_zero_o(lvl0),
		.level_code_bit_one_o(lvl1), .alarm_low_o(alo), .alarm_high_o(ahi), .irq_o(irq));

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Pins settle one edge after a source change; wait two to be safe
	task automatic chk_out(input logic l, input logic h, input logic [7:0] d, input logic [1:0] c);
		repeat (2) @(posedge clk_i);
		#1;
		check("alarm_low", {7'h0, l}, {7'h0, alo});
		check("alarm_high", {7'h0, h}, {7'h0, ahi});
		check("dout", d, dout);
		check("level", {6'h0, c}, {6'h0, lvl1, lvl0});
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask

	// Read answer stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
		@(posedge clk_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1;
		check(what, exp, rdata_o);
	endtask

	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Clock, watchdog, main sequence
	// ------------------------------------------------------------
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	// Whole run needs a few hundred cycles
	initial begin
		#200000;
		fails++;
		$display("watchdog expired");
		stop_test();
	end

	initial begin
		{sys_rst_i, addr_i, wdata_i, wr_i, rd_i} = {1'b1, 18'h0};
		repeat (10) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		for (i = 0; i < 5; i++) rd(8'h1e + i[7:0], 8'h00, "reset byte");
		for (i = 0; i < 5; i++) wr(8'h1e + i[7:0], 8'h5a ^ i[7:0]);
		for (i = 0; i < 5; i++) rd(8'h1e + i[7:0], 8'h5a ^ i[7:0], "rw byte");
		rd(8'h50, 8'h00, "unmapped");
		$display("registers test done");
		wr(als_pkg::ALS_OFS_LO_TRIG, 8'h40);
		wr(als_pkg::ALS_OFS_LO_OUT, 8'h11);
		wr(als_pkg::ALS_OFS_HI_TRIG, 8'hc0);
		wr(als_pkg::ALS_OFS_HI_OUT, 8'hee);
		wr(als_pkg::ALS_OFS_IRQ_MASK, 8'h03);
		wr(als_pkg::ALS_OFS_CTRL, 8'h01);
		for (s = 0; s < 6; s++) begin
			wr(als_pkg::ALS_OFS_SEL, {s[2:0], 5'h00});
			m.drive(s, 8'h40, 8'h80);
			chk_out(s > 3, 1'b0, (s > 3) ? 8'h11 : 8'h5a, 2'h0);
			if (s < 4) begin
				m.drive(s, 8'h3f, 8'h80);
				chk_out(1'b1, 1'b0, 8'h11, 2'h0);
				m.drive(s, 8'hc1, 8'h80);
				chk_out(1'b0, 1'b1, 8'hee, 2'h0);
				m.drive(s, 8'hc0, 8'h3f);
				chk_out(1'b0, 1'b0, 8'h5a, 2'h0);
			end
		end
		check("irq", 8'h01, {7'h0, irq});
		rd(als_pkg::ALS_OFS_IRQ_ST, 8'h03, "irq status");
		wr(als_pkg::ALS_OFS_IRQ_ST, 8'h03);
		wr(als_pkg::ALS_OFS_IRQ_MASK, 8'h00);
		#1;
		check("irq cleared", 8'h00, {7'h0, irq});
		// Back to the temperature source, in range, so the next drop is a fresh entry
		wr(als_pkg::ALS_OFS_SEL, 8'h00);
		m.drive(0, 8'h10, 8'h80);
		chk_out(1'b1, 1'b0, 8'h11, 2'h0);
		check("irq masked", 8'h00, {7'h0, irq});
		rd(als_pkg::ALS_OFS_STAT, 8'h21, "status low");
		rd(als_pkg::ALS_OFS_DOUT, 8'h11, "dout reg");
		$display("alarm test done");
		wr(als_pkg::ALS_OFS_CTRL, 8'h0d);
		chk_out(1'b0, 1'b0, 8'h5a, 2'h0);
		$display("output stage test done");
		wr(als_pkg::ALS_OFS_LO_OUT, 8'h80);
		wr(als_pkg::ALS_OFS_CTRL, 8'h03);
		for (s = 0; s < 4; s++) begin
			wr(als_pkg::ALS_OFS_SEL, {1'b1, s[1:0], 5'h00});
			for (i = 0; i < 6; i++) begin
				m.drive(s, vals[i], 8'hff);
				chk_out(1'b0, 1'b0, 8'h5a, codes[i]);
			end
		end
		rd(als_pkg::ALS_OFS_STAT, 8'h80, "status level");
		rd(als_pkg::ALS_OFS_IRQ_ST, 8'h05, "irq status level");
		wr(als_pkg::ALS_OFS_IRQ_MASK, 8'h04);
		#1;
		check("irq level", 8'h01, {7'h0, irq});
		$display("level test done");
		@(posedge clk_i);
		sys_rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		rd(als_pkg::ALS_OFS_SEL, 8'h00, "byte after reset");
		check("irq after reset", 8'h00, {7'h0, irq});
		$display("reset test done");
		stop_test();
	end
endmodule

bind als_top als_top_sva #(.DW(DW)) u_sva (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
	.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
	.temp_i(temp_i), .amp_i(amp_i), .gain_i(gain_i), .volt_i(volt_i),
	.normal_value_i(normal_value_i), .digital_output_value_o(digital_output_value_o),
	.level_code_bit_zero_o(level_code_bit_zero_o), .level_code_bit_one_o(level_code_bit_one_o),
	.alarm_low_o(alarm_low_o), .alarm_high_o(alarm_high_o), .irq_o(irq_o));
`default_nettype wire
